/* File: hdl/scrctl_host.sv */
// Operation
// - Address first, setup wait, select held low.
// - Address held stable after strobe release.
// - Same address pattern reaches same word always.
// - Address and data lines may be permuted.
`timescale 1ns/1ps

`include "scrctl_regs.svh"

module scrctl_host
	import scrctl_pkg::*;
#(
	parameter int                        ASETUP_CYC = `SCRCTL_ASETUP_CYC,
	parameter int                        AHOLD_CYC  = `SCRCTL_AHOLD_CYC,
	parameter int                        WPULSE_CYC = `SCRCTL_WPULSE_CYC,
	parameter int                        DSETUP_CYC = `SCRCTL_DSETUP_CYC,
	parameter int                        ACCESS_CYC = `SCRCTL_ACCESS_CYC,
	parameter logic [`SCRCTL_ADDR_W-1:0] ADDR_INV   = `SCRCTL_ADDR_INV,
	parameter logic                      ADDR_REV   = `SCRCTL_ADDR_REV,
	parameter logic                      DATA_REV   = `SCRCTL_DATA_REV
)
(
	input  wire  logic                     CLK,
	input  wire  logic                     RESET_N,
	input  wire  logic                     CMD_VALID,
	input  wire  logic                     CMD_WRITE,
	input  wire  scrctl_pkg::scrctl_addr_t CMD_ADDR,
	input  wire  scrctl_pkg::scrctl_data_t CMD_WDATA,
	output logic                           CMD_READY,
	output logic                           RSP_VALID,
	output scrctl_pkg::scrctl_data_t       RSP_RDATA,
	output scrctl_pkg::scrctl_addr_t       WORD_ADDR,
	output scrctl_pkg::scrctl_data_t       WRITE_DATA,
	output logic                           SELECT_N,
	output logic                           WRITE_N,
	input  wire  scrctl_pkg::scrctl_data_t READ_DATA_N
);
	import scrctl_pkg::*;

	// ======================================================================
	// Derived counts
	// ======================================================================
	localparam int PULSE_CYC = (WPULSE_CYC > DSETUP_CYC) ?
		WPULSE_CYC : DSETUP_CYC;
	localparam scrctl_cnt_t SET_LD = scrctl_cnt_t'(ASETUP_CYC - 1);
	localparam scrctl_cnt_t PUL_LD = scrctl_cnt_t'(PULSE_CYC - 1);
	localparam scrctl_cnt_t HLD_LD = scrctl_cnt_t'(AHOLD_CYC - 1);
	localparam scrctl_cnt_t ACC_LD = scrctl_cnt_t'(ACCESS_CYC - 1);

	scrctl_state_e state;
	scrctl_cnt_t   cnt;
	scrctl_addr_t  cur_addr;
	scrctl_data_t  cur_data;
	scrctl_addr_t  map_addr;
	scrctl_data_t  map_data;
	scrctl_data_t  map_rdata;
	logic          accept;
	logic          cnt_done;

	assign accept   = CMD_VALID && CMD_READY;
	assign cnt_done = (cnt == '0);

	// ======================================================================
	// Pin mapping of the incoming command and the returned read lines.
	// ======================================================================
	scrctl_map
	#(
		.ADDR_INV (ADDR_INV),
		.ADDR_REV (ADDR_REV),
		.DATA_REV (DATA_REV)
	)
	u_map
	(
		.addr_in    (CMD_ADDR),
		.data_in    (CMD_WDATA),
		.pin_data_n (READ_DATA_N),
		.addr_out   (map_addr),
		.data_out   (map_data),
		.rdata      (map_rdata)
	);

	// ======================================================================
	// Sequencer: one step per phase of a write or read cycle.
	// ======================================================================
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			state <= ST_IDLE;
		else
			unique case (state)
				ST_IDLE:
					if (accept)
						state <= CMD_WRITE ? ST_SETUP : ST_ACCESS;
				ST_SETUP:
					if (cnt_done)
						state <= ST_PULSE;
				ST_PULSE:
					if (cnt_done)
						state <= ST_HOLD;
				ST_HOLD:
					if (cnt_done)
						state <= ST_IDLE;
				ST_ACCESS:
					if (cnt_done)
						state <= ST_IDLE;
				default:
					state <= ST_IDLE;
			endcase
	end

	// Phase counter, loaded on entry to each timed phase.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			cnt <= '0;
		else if (state == ST_IDLE && accept)
			cnt <= CMD_WRITE ? SET_LD : ACC_LD;
		else if (!cnt_done)
			cnt <= cnt - 8'h01;
		else if (state == ST_SETUP)
			cnt <= PUL_LD;
		else if (state == ST_PULSE)
			cnt <= HLD_LD;
	end

	// Address, data and the logical copy change only on acceptance, so
	// they stay stable through setup, pulse and hold.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			WORD_ADDR  <= '0;
			WRITE_DATA <= '0;
			cur_addr   <= '0;
			cur_data   <= '0;
		end
		else if (accept)
		begin
			WORD_ADDR  <= map_addr;
			WRITE_DATA <= map_data;
			cur_addr   <= CMD_ADDR;
			cur_data   <= CMD_WDATA;
		end
	end

	// Select goes low with the address and high after hold or access.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			SELECT_N <= 1'b1;
		else if (accept)
			SELECT_N <= 1'b0;
		else if ((state == ST_HOLD || state == ST_ACCESS) && cnt_done)
			SELECT_N <= 1'b1;
	end

	// Write strobe is low for the whole pulse phase only.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			WRITE_N <= 1'b1;
		else if (state == ST_SETUP && cnt_done)
			WRITE_N <= 1'b0;
		else if (state == ST_PULSE && cnt_done)
			WRITE_N <= 1'b1;
	end

	// Ready drops on acceptance and returns when the cycle ends.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			CMD_READY <= 1'b1;
		else if (accept)
			CMD_READY <= 1'b0;
		else if ((state == ST_HOLD || state == ST_ACCESS) && cnt_done)
			CMD_READY <= 1'b1;
	end

	// Completion pulse, and read data sampled after the access time.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			RSP_VALID <= 1'b0;
			RSP_RDATA <= '0;
		end
		else
		begin
			RSP_VALID <= (state == ST_HOLD || state == ST_ACCESS) && cnt_done;
			if (state == ST_ACCESS && cnt_done)
				RSP_RDATA <= map_rdata;
		end
	end

	// ======================================================================
	// Checks on the pin sequence
	// ======================================================================
	localparam int RD_MAX = 300;

	scrctl_cnt_t low_cnt;

	// Length of the current write strobe, for the pulse check.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			low_cnt <= '0;
		else if (!WRITE_N)
			low_cnt <= low_cnt + 8'h01;
		else
			low_cnt <= '0;
	end

	sequence s_release;
		$rose(WRITE_N);
	endsequence

	sequence s_hold;
		$stable(WORD_ADDR) && $stable(WRITE_DATA);
	endsequence

	a_addr_before_strobe: assert property (@(posedge CLK)
		disable iff (!RESET_N)
		$fell(WRITE_N) |-> $stable(WORD_ADDR) && !$past(SELECT_N))
		else $error("Strobe fell without settled address and select.");

	a_select_in_write: assert property (@(posedge CLK)
		disable iff (!RESET_N)
		!WRITE_N |-> !SELECT_N)
		else $error("Write strobe low while select is high.");

	a_pulse_width: assert property (@(posedge CLK)
		disable iff (!RESET_N)
		$rose(WRITE_N) |-> low_cnt == scrctl_cnt_t'(PULSE_CYC))
		else $error("Write strobe width differs from the pulse count.");

	a_addr_hold: assert property (@(posedge CLK)
		disable iff (!RESET_N)
		s_release |-> s_hold ##1 s_hold)
		else $error("Address or data changed inside the hold time.");

	a_addr_map: assert property (@(posedge CLK)
		disable iff (!RESET_N)
		!SELECT_N |-> $countones(WORD_ADDR ^ ADDR_INV) ==
			$countones(cur_addr))
		else $error("Pin address is not a map of the logical address.");

	a_data_map: assert property (@(posedge CLK)
		disable iff (!RESET_N)
		!SELECT_N |-> $countones(WRITE_DATA) == $countones(cur_data))
		else $error("Pin data is not a permutation of the write data.");

	a_read_done: assert property (@(posedge CLK)
		disable iff (!RESET_N)
		(accept && !CMD_WRITE) |-> ##[1:RD_MAX] RSP_VALID)
		else $error("Read did not complete in time.");

endmodule : scrctl_host

/* File: hdl/scrctl_regs.svh */
`ifndef SCRCTL_REGS_SVH
`define SCRCTL_REGS_SVH

// ==========================================================================
// Memory geometry
// ==========================================================================
`define SCRCTL_ADDR_W       4
`define SCRCTL_DATA_W       4
`define SCRCTL_WORDS        16

// ==========================================================================
// Clock and pin timing, in nanoseconds
// ==========================================================================
`define SCRCTL_CLK_NS       100
`define SCRCTL_T_ASETUP_NS  0
`define SCRCTL_T_AHOLD_NS   45
`define SCRCTL_T_DSETUP_NS  30
`define SCRCTL_T_WPULSE_NS  45
`define SCRCTL_T_ACCESS_NS  55

// ==========================================================================
// Conversion of a least time to whole cycles, never below one cycle
// ==========================================================================
`define SCRCTL_CYC(ns) ((((ns) + `SCRCTL_CLK_NS - 1) / `SCRCTL_CLK_NS) < 1 ? \
	1 : (((ns) + `SCRCTL_CLK_NS - 1) / `SCRCTL_CLK_NS))

`define SCRCTL_ASETUP_CYC   `SCRCTL_CYC(`SCRCTL_T_ASETUP_NS)
`define SCRCTL_AHOLD_CYC    `SCRCTL_CYC(`SCRCTL_T_AHOLD_NS)
`define SCRCTL_DSETUP_CYC   `SCRCTL_CYC(`SCRCTL_T_DSETUP_NS)
`define SCRCTL_WPULSE_CYC   `SCRCTL_CYC(`SCRCTL_T_WPULSE_NS)
`define SCRCTL_ACCESS_CYC   `SCRCTL_CYC(`SCRCTL_T_ACCESS_NS)

// ==========================================================================
// Wiring options, the default is straight wiring
// ==========================================================================
`define SCRCTL_ADDR_INV     4'h0
`define SCRCTL_ADDR_REV     1'b0
`define SCRCTL_DATA_REV     1'b0

`endif

/* File: hdl/scrctl_pkg.sv */
`include "scrctl_regs.svh"

package scrctl_pkg;

	// ======================================================================
	// Types
	// ======================================================================
	typedef logic [`SCRCTL_ADDR_W-1:0] scrctl_addr_t;
	typedef logic [`SCRCTL_DATA_W-1:0] scrctl_data_t;
	typedef logic [7:0]                scrctl_cnt_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SETUP  = 3'b001,
		ST_PULSE  = 3'b010,
		ST_HOLD   = 3'b011,
		ST_ACCESS = 3'b100
	} scrctl_state_e;

endpackage : scrctl_pkg

/* File: hdl/scrctl_map.sv */
`timescale 1ns/1ps

`include "scrctl_regs.svh"

// ==========================================================================
// Board wiring map between logical and pin bit order
// ==========================================================================
module scrctl_map
#(
	parameter logic [`SCRCTL_ADDR_W-1:0] ADDR_INV = `SCRCTL_ADDR_INV,
	parameter logic                      ADDR_REV = `SCRCTL_ADDR_REV,
	parameter logic                      DATA_REV = `SCRCTL_DATA_REV
)
(
	input  wire  scrctl_pkg::scrctl_addr_t addr_in,
	input  wire  scrctl_pkg::scrctl_data_t data_in,
	input  wire  scrctl_pkg::scrctl_data_t pin_data_n,
	output       scrctl_pkg::scrctl_addr_t addr_out,
	output       scrctl_pkg::scrctl_data_t data_out,
	output       scrctl_pkg::scrctl_data_t rdata
);
	import scrctl_pkg::*;

	genvar i;

	// ======================================================================
	// Address: the same map serves reads and writes, so any mix of true
	// and inverted lines, in straight or reversed order, reaches one physical word.
	// ======================================================================
	generate
		for (i = 0; i < `SCRCTL_ADDR_W; i++)
		begin : g_addr
			localparam int SRC = ADDR_REV ? (`SCRCTL_ADDR_W - 1 - i) : i;
			assign addr_out[i] = addr_in[SRC] ^ ADDR_INV[i];
		end
	endgenerate

	// ======================================================================
	// Data: write lines and read lines use one permutation, and the read
	// lines are inverting, so they are complemented on the way in.
	// ======================================================================
	generate
		for (i = 0; i < `SCRCTL_DATA_W; i++)
		begin : g_data
			localparam int SRC = DATA_REV ? (`SCRCTL_DATA_W - 1 - i) : i;
			assign data_out[i] = data_in[SRC];
			assign rdata[SRC]  = ~pin_data_n[i];
		end
	endgenerate

endmodule : scrctl_map

/* File: verification/scrctl_mem.sv */
`timescale 1ns/1ps

// ======================================================================
// Behavioural model of the scratch-pad memory on the pin side
// ======================================================================
module scrctl_mem
#(
	parameter logic OPEN_COLL = 1'b1
)
(
	input  wire  scrctl_pkg::scrctl_addr_t word_addr,
	input  wire  scrctl_pkg::scrctl_data_t write_data,
	input  wire  logic                     select_n,
	input  wire  logic                     write_n,
	output scrctl_pkg::scrctl_data_t       read_data_n
);
	import scrctl_pkg::*;

	scrctl_data_t mem [16];
	scrctl_data_t last;

	// Arbitrary power-up contents; with the bench wiring, 8 of the 16 words already hold the value that t_fill writes.
	initial
	begin
		last = 4'h0;
		for (int i = 0; i < 16; i++)
			mem[i] = 4'(i * 7 + 3);
	end

	// Words are stored only while select and strobe are both low.
	always @*
	begin
		if (!select_n && !write_n)
			mem[word_addr] = write_data;
	end

	// A read drives the inverted word, which is valid at once after a write.
	always @*
	begin
		if (!select_n && write_n)
		begin
			read_data_n = ~mem[word_addr];
			last = read_data_n;
		end
		else if (OPEN_COLL)
			read_data_n = 4'hF;
		else
			read_data_n = ~last;
	end

endmodule : scrctl_mem

/* File: verification/scratchpad_ram_16x4_bench.sv */
`timescale 1ns/1ps

// ======================================================================
// Self-checking bench for the scratch-pad host controller
// ======================================================================
module scratchpad_ram_16x4_bench;
	import scrctl_pkg::*;

	localparam int ASETUP = 1;
	localparam int PULSE  = 2;
	localparam int AHOLD  = 2;
	localparam int ACCESS = 1;

	logic         clk       = 1'b0;
	logic         reset_n   = 1'b0;
	logic         cmd_valid = 1'b0;
	logic         cmd_write = 1'b0;
	scrctl_addr_t cmd_addr  = 4'h0;
	scrctl_data_t cmd_wdata = 4'h0;
	logic         cmd_ready, rsp_valid, select_n, write_n;
	scrctl_addr_t word_addr, prev_addr;
	scrctl_data_t rsp_rdata, write_data, read_data_n, got, prev_data;
	scrctl_data_t expd [16];
	logic         prev_sel_n = 1'b1;
	logic         prev_wr_n  = 1'b1;
	int           n_fail = 0;
	int           checks = 0;
	int           cycles = 0;
	int           sel_cnt = 0;
	int           low_cnt = 0;
	int           hold_cnt = 0;

	// Inverted and reversed wiring shows that the mapping reaches one word.
	scrctl_host #(.ASETUP_CYC(ASETUP), .AHOLD_CYC(AHOLD), .WPULSE_CYC(PULSE),
		.DSETUP_CYC(1), .ACCESS_CYC(ACCESS), .ADDR_INV(4'h5),
		.ADDR_REV(1'b1), .DATA_REV(1'b1)) i_dut (
		.CLK(clk), .RESET_N(reset_n), .CMD_VALID(cmd_valid),
		.CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
		.CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
		.WORD_ADDR(word_addr), .WRITE_DATA(write_data),
		.SELECT_N(select_n), .WRITE_N(write_n), .READ_DATA_N(read_data_n));

	scrctl_mem #(.OPEN_COLL(1'b1)) i_mem (.word_addr(word_addr),
		.write_data(write_data), .select_n(select_n), .write_n(write_n),
		.read_data_n(read_data_n));

	// The clock runs at 10 MHz.
	always #50 clk = ~clk;

	// ==================================================================
	// Comparison, verdict and hang guard
	// ==================================================================
	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	// A hung handshake ends the run as a mismatch.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			complete_run();
		end
	end

	// Pin monitor: strobe inside select, fixed setup, pulse and hold counts.
	always @(posedge clk)
	begin
		if (reset_n)
		begin
			if (write_n === 1'b0)
				check("strobe_sel", select_n, 1'b0);
			if (select_n === 1'b0 && prev_sel_n === 1'b0)
			begin
				check("addr_stable", word_addr, prev_addr);
				check("data_stable", write_data, prev_data);
			end
			if (write_n === 1'b0 && prev_wr_n === 1'b1)
				check("setup", 8'(sel_cnt), 8'(ASETUP));
			if (write_n === 1'b1 && prev_wr_n === 1'b0)
				check("pulse", 8'(low_cnt), 8'(PULSE));
			if (select_n === 1'b1 && prev_sel_n === 1'b0 && low_cnt > 0)
				check("hold", 8'(hold_cnt), 8'(AHOLD));
		end
		if (select_n !== 1'b0)
		begin
			sel_cnt = 0;
			low_cnt = 0;
			hold_cnt = 0;
		end
		else if (write_n === 1'b0)
			low_cnt++;
		else if (low_cnt == 0)
			sel_cnt++;
		else
			hold_cnt++;
		prev_sel_n = select_n;
		prev_wr_n = write_n;
		prev_addr = word_addr;
		prev_data = write_data;
	end

	// ==================================================================
	// Command driver and scenarios
	// ==================================================================
	task automatic do_cmd(input logic wr, input scrctl_addr_t a,
		input scrctl_data_t d);
		int         k;
		logic [7:0] lat;
		lat = wr ? 8'(ASETUP + PULSE + AHOLD + 1) : 8'(ACCESS + 1);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_addr <= a;
		cmd_wdata <= d;
		k = 0;
		@(posedge clk);
		while (cmd_ready !== 1'b1 && k < 20)
		begin
			k++;
			@(posedge clk);
		end
		cmd_valid <= 1'b0;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
			if (rsp_valid !== 1'b1)
				check("busy", cmd_ready, 1'b0);
		end
		while (rsp_valid !== 1'b1 && k < 20);
		got = rsp_rdata;
		check("ready", cmd_ready, 1'b1);
		check("latency", 8'(k), lat);
	endtask : do_cmd

	task automatic read_all();
		for (int a = 0; a < 16; a++)
		begin
			do_cmd(1'b0, 4'(a), 4'h0);
			check("rdata", got, expd[a]);
		end
	endtask : read_all

	task automatic t_reset();
		check("rst_sel", select_n, 1'b1);
		check("rst_wr", write_n, 1'b1);
	endtask : t_reset

	task automatic t_fill();
		for (int a = 0; a < 16; a++)
		begin
			expd[a] = 4'(a) ^ 4'h6;
			do_cmd(1'b1, 4'(a), expd[a]);
		end
		read_all();
	endtask : t_fill

	task automatic t_back2back();
		for (int i = 0; i < 2; i++)
		begin
			expd[3] = (i == 0) ? 4'hF : 4'h0;
			do_cmd(1'b1, 4'h3, expd[3]);
			do_cmd(1'b0, 4'h3, 4'h0);
			check("recover", got, expd[3]);
		end
	endtask : t_back2back

	task automatic t_idle_keep();
		repeat (8)
		begin
			@(posedge clk);
			check("idle_sel", select_n, 1'b1);
		end
		read_all();
	endtask : t_idle_keep

	// Reset for five cycles, then run every scenario in turn.
	initial
	begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_fill();
		t_back2back();
		t_idle_keep();
		complete_run();
	end

endmodule : scratchpad_ram_16x4_bench
